//--- src/brs_bridge_regs.sv
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
module brs_bridge_regs
    import brs_pkg::*;
#(
    parameter int EE_BYTES = 512,
    parameter int EE_AW = 9
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    input wire logic firstModeStrapPin,
    input wire logic receiverSupplyInput,
    input wire logic videoRxIrqIn,
    input wire logic protectTxIrqIn,
    input wire logic extTimebaseTick,
    output logic cecTick,
    output logic eeReq,
    output logic [EE_AW-1:0] eeAddr,
    input wire logic eeAck,
    input wire logic [7:0] eeData,
    output logic idWrEn,
    output logic [7:0] idWrAddr,
    output logic [7:0] idWrData,
    output logic displayIdDdcBlock,
    input wire logic remoteIdLoadDone,
    input wire logic remoteIdSumOk,
    output logic pbReadReq,
    output logic [15:0] pbAddr,
    input wire logic pbReadDone,
    input wire logic [31:0] pbReadData,
    output logic [15:0] pbLowData
);
    localparam logic [EE_AW-1:0] CFG_BASE = EE_BYTES[EE_AW-1:0] - CFG_REGION_BYTES[EE_AW-1:0];
    localparam logic [8:0] CFG_LAST = 9'(CFG_REGION_BYTES - 1);
    localparam logic [8:0] ID_LAST = 9'(ID_REGION_BYTES - 1);
    logic wrPend_q, rdPend_q, strapCaught_q, supplyLvl_q, extLvl_q, cecTick_q, eeReq_q, idWrEn_q, readStart_q;
    logic srcSel_q, genOn_q, wipe_q, reload_q, ddcBlock_q, cfgDone_q, initDone_q, remoteLoaded_q, cfgOk_q, idOk_q;
    logic [7:0] wrIdx_q, rdIdx_q, dataByte2_q, dataByte3_q, sum_q, idWrAddr_q, idWrData_q, wdat;
    logic [31:0] hrdata_q;
    logic [2:0] strapSync_q, supplySync_q, extSync_q;
    logic [1:0] strapCnt_q;
    logic [CEC_ACC_W-1:0] acc_q;
    logic [8:0] byteCnt_q, accSum;
    logic [EE_AW-1:0] eeAddr_q;
    logic [IRQ_W-1:0] irqStat_q, irqMask_q, irqSet;
    logic [15:0] pbAddr_q, pbLowData_q;
    logic accept, wrHit, eeDone, lastCfg, lastId, lastWipe, reloadGo;
    brs_seq_t state_q;
    brs_ctrl_t ctrlView;
    brs_status_t statView;

    function automatic logic [31:0] readMux(input logic [7:0] idx, input brs_ctrl_t c,
            input brs_status_t s, input logic [7:0] d2, input logic [7:0] d3,
            input logic [IRQ_W-1:0] ist, input logic [IRQ_W-1:0] imk,
            input logic rs, input logic [15:0] pa);
        logic [31:0] r;
        case (idx)
            IDX_DATA2: r = {24'h00_0000, d2};
            IDX_DATA3: r = {24'h00_0000, d3};
            IDX_CTRL: r = {24'h00_0000, c};
            IDX_STATUS: r = {24'h00_0000, s};
            IDX_IRQ_STAT: r = {27'h000_0000, ist};
            IDX_IRQ_MASK: r = {27'h000_0000, imk};
            IDX_IND_CTRL: r = {31'h0000_0000, rs};
            IDX_IND_ADDR: r = {16'h0000, pa};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // words only; hsize is not checked, unmapped reads return zero
    assign accept = hsel && htrans[1] && hready;
    assign hreadyout = !rdPend_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign wrHit = wrPend_q;
    assign wdat = hwdata[7:0];

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            wrIdx_q <= 8'h00;
            rdIdx_q <= 8'h00;
        end else begin
            wrPend_q <= accept && hwrite && haddr[31:10] == 22'h00_0000 && haddr[1:0] == 2'h0;
            rdPend_q <= accept && !hwrite;
            if (accept) begin
                wrIdx_q <= haddr[9:2];
                rdIdx_q <= (haddr[31:10] == 22'h00_0000 && haddr[1:0] == 2'h0) ? haddr[9:2] : 8'hff;
            end
        end
    end

    // one wait state so a read just after a write sees the new value
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rdPend_q) begin
            hrdata_q <= readMux(rdIdx_q, ctrlView, statView, dataByte2_q, dataByte3_q,
                irqStat_q, irqMask_q, readStart_q, pbAddr_q);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            dataByte2_q <= DATA_RST;
            dataByte3_q <= DATA_RST;
            pbLowData_q <= 16'h0000;
        end else if (readStart_q && pbReadDone) begin
            dataByte2_q <= pbReadData[23:16];
            dataByte3_q <= pbReadData[31:24];
            pbLowData_q <= pbReadData[15:0];
        end else if (wrHit && wrIdx_q == IDX_DATA2) begin
            dataByte2_q <= wdat;
        end else if (wrHit && wrIdx_q == IDX_DATA3) begin
            dataByte3_q <= wdat;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            readStart_q <= 1'b0;
            pbAddr_q <= 16'h0000;
        end else begin
            if (readStart_q && pbReadDone) begin
                readStart_q <= 1'b0;
            end else if (wrHit && wrIdx_q == IDX_IND_CTRL && hwdata[IND_START_BIT]) begin
                readStart_q <= 1'b1;
            end
            if (wrHit && wrIdx_q == IDX_IND_ADDR && !readStart_q) begin
                pbAddr_q <= hwdata[15:0];
            end
        end
    end

    assign pbReadReq = readStart_q;
    assign pbAddr = pbAddr_q;
    assign pbLowData = pbLowData_q;
    // reload is only taken when the load sequence is idle
    assign reloadGo = wrHit && wrIdx_q == IDX_CTRL && hwdata[CTL_RELOAD_BIT] && state_q == ST_RUN;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            srcSel_q <= 1'b0;
            genOn_q <= 1'b0;
        end else if (wrHit && wrIdx_q == IDX_CTRL) begin
            srcSel_q <= hwdata[CTL_SRC_BIT];
            genOn_q <= hwdata[CTL_GEN_BIT];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reload_q <= 1'b0;
            wipe_q <= 1'b0;
        end else if (reloadGo) begin
            reload_q <= 1'b1;
            wipe_q <= hwdata[CTL_WIPE_BIT];
        end else if ((lastId || lastWipe) && reload_q) begin
            reload_q <= 1'b0;
            wipe_q <= 1'b0;
        end
    end
    // strap caught once after release, once the synchroniser has settled
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            strapSync_q <= 3'h0;
            strapCnt_q <= 2'h0;
            strapCaught_q <= 1'b0;
            ddcBlock_q <= 1'b0;
        end else begin
            strapSync_q <= {strapSync_q[1:0], firstModeStrapPin};
            if (strapCnt_q != 2'(STRAP_SETTLE)) begin
                strapCnt_q <= strapCnt_q + 2'h1;
            end else if (!strapCaught_q && strapSync_q[1] == strapSync_q[2]) begin
                ddcBlock_q <= strapSync_q[2];
                strapCaught_q <= 1'b1;
            end
        end
    end

    assign displayIdDdcBlock = ddcBlock_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            supplySync_q <= 3'h0;
            supplyLvl_q <= 1'b0;
            extSync_q <= 3'h0;
            extLvl_q <= 1'b0;
        end else begin
            supplySync_q <= {supplySync_q[1:0], receiverSupplyInput};
            extSync_q <= {extSync_q[1:0], extTimebaseTick};
            if (supplySync_q[1] == supplySync_q[2]) begin
                supplyLvl_q <= supplySync_q[2];
            end
            if (extSync_q[1] == extSync_q[2]) begin
                extLvl_q <= extSync_q[2];
            end
        end
    end
    // internal source: phase accumulator gives 32.768 kHz average, jitter of one cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            acc_q <= '0;
            cecTick_q <= 1'b0;
        end else if (!genOn_q) begin
            acc_q <= '0;
            cecTick_q <= 1'b0;
        end else begin
            acc_q <= acc_q + CEC_ACC_INC;
            if (srcSel_q) begin
                cecTick_q <= extLvl_q == 1'b0 && extSync_q[2] == 1'b1 && extSync_q[1] == 1'b1;
            end else begin
                cecTick_q <= acc_q > (acc_q + CEC_ACC_INC);
            end
        end
    end

    assign cecTick = cecTick_q;
    assign eeDone = eeReq_q && eeAck;
    assign accSum = {1'b0, sum_q} + {1'b0, eeData};
    assign lastCfg = state_q == ST_CFG && eeDone && byteCnt_q == CFG_LAST;
    assign lastId = state_q == ST_ID && eeDone && byteCnt_q == ID_LAST;
    assign lastWipe = state_q == ST_WIPE && byteCnt_q == ID_LAST;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_q <= ST_CFG;
            byteCnt_q <= 9'h000;
            sum_q <= 8'h00;
            eeReq_q <= 1'b0;
            eeAddr_q <= CFG_BASE;
        end else begin
            case (state_q)
                ST_CFG, ST_ID: begin
                    if (eeDone) begin
                        eeReq_q <= 1'b0;
                        sum_q <= accSum[7:0];
                        byteCnt_q <= byteCnt_q + 9'h001;
                        eeAddr_q <= eeAddr_q + 1'b1;
                        if (lastCfg) begin
                            state_q <= ST_ID;
                            byteCnt_q <= 9'h000;
                            sum_q <= 8'h00;
                            eeAddr_q <= '0;
                        end else if (lastId) begin
                            state_q <= ST_RUN;
                        end
                    end else if (!eeReq_q) begin
                        eeReq_q <= 1'b1;
                    end
                end
                ST_WIPE: begin
                    byteCnt_q <= byteCnt_q + 9'h001;
                    if (lastWipe) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    byteCnt_q <= 9'h000;
                    sum_q <= 8'h00;
                    eeAddr_q <= '0;
                    if (reloadGo) begin
                        state_q <= hwdata[CTL_WIPE_BIT] ? ST_WIPE : ST_ID;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    assign eeReq = eeReq_q;
    assign eeAddr = eeAddr_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            idWrEn_q <= 1'b0;
            idWrAddr_q <= 8'h00;
            idWrData_q <= 8'h00;
        end else begin
            idWrEn_q <= (state_q == ST_ID && eeDone) || state_q == ST_WIPE;
            idWrAddr_q <= byteCnt_q[7:0];
            idWrData_q <= state_q == ST_WIPE ? 8'h00 : eeData;
        end
    end

    assign idWrEn = idWrEn_q;
    assign idWrAddr = idWrAddr_q;
    assign idWrData = idWrData_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cfgDone_q <= 1'b0;
            initDone_q <= 1'b0;
            cfgOk_q <= STATUS_RST[1];
            idOk_q <= STATUS_RST[0];
            remoteLoaded_q <= 1'b0;
        end else begin
            if (lastCfg) begin
                cfgDone_q <= 1'b1;
                cfgOk_q <= accSum[7:0] == 8'h00;
            end
            if (lastId) begin
                initDone_q <= 1'b1;
                idOk_q <= accSum[7:0] == 8'h00;
            end else if (remoteIdLoadDone && state_q == ST_RUN) begin
                remoteLoaded_q <= 1'b1;
                idOk_q <= remoteIdSumOk;
            end
        end
    end

    always_comb begin
        ctrlView = '0;
        ctrlView.cecTimebaseSourceSel = srcSel_q;
        ctrlView.cecTimebaseGenOn = genOn_q;
        ctrlView.displayIdMemWipe = wipe_q;
        ctrlView.displayIdMemReload = reload_q;
        ctrlView.displayIdDdcBlock = ddcBlock_q;
    end
    always_comb begin
        statView.receiverSupplySense = supplyLvl_q;
        statView.videoRxIrqPending = videoRxIrqIn;
        statView.protectTxIrqPending = protectTxIrqIn;
        statView.initDone = initDone_q;
        statView.remoteDisplayIdLoaded = remoteLoaded_q;
        statView.cfgDone = cfgDone_q;
        statView.configChecksumOk = cfgOk_q;
        statView.displayIdChecksumOk = idOk_q;
    end
    always_comb begin
        irqSet = '0;
        irqSet[IRQ_CFG_DONE] = lastCfg;
        irqSet[IRQ_INIT_DONE] = lastId && !initDone_q;
        irqSet[IRQ_RELOAD_DONE] = (lastId || lastWipe) && reload_q;
        irqSet[IRQ_REMOTE_LOAD] = remoteIdLoadDone && state_q == ST_RUN;
        irqSet[IRQ_READ_DONE] = readStart_q && pbReadDone;
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irqStat_q <= '0;
            irqMask_q <= '0;
        end else begin
            if (wrHit && wrIdx_q == IDX_IRQ_STAT) begin
                irqStat_q <= (irqStat_q & ~hwdata[IRQ_W-1:0]) | irqSet;
            end else begin
                irqStat_q <= irqStat_q | irqSet;
            end
            if (wrHit && wrIdx_q == IDX_IRQ_MASK) begin
                irqMask_q <= hwdata[IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irqStat_q & irqMask_q);
    a_init_order: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(initDone_q) |-> cfgDone_q && $past(cfgDone_q))
        else $error("init done before configuration done");
    a_reload_self: assert property (@(posedge ref_clk) disable iff (!rstn)
        (lastId && reload_q) |=> !reload_q && state_q == ST_RUN)
        else $error("reload bit not cleared after reload");
    a_wipe_pair: assert property (@(posedge ref_clk) disable iff (!rstn)
        wipe_q |-> reload_q && (state_q == ST_WIPE || $past(state_q) == ST_WIPE || $past(reloadGo)))
        else $error("wipe without reload");
    a_strap_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        strapCaught_q && $past(strapCaught_q) |-> $stable(ddcBlock_q))
        else $error("strap bit changed after capture");
    a_supply_flow: assert property (@(posedge ref_clk) disable iff (!rstn)
        (supplySync_q[2] && supplySync_q[1]) |=> supplyLvl_q)
        else $error("supply sense not followed");
    a_tick_off: assert property (@(posedge ref_clk) disable iff (!rstn)
        !genOn_q |=> !cecTick_q)
        else $error("timebase tick while disabled");
    a_tick_gap: assert property (@(posedge ref_clk) disable iff (!rstn)
        (cecTick_q && !srcSel_q && genOn_q && !wrHit) |=> !cecTick_q [*8])
        else $error("internal timebase ticks too fast");
    a_read_done: assert property (@(posedge ref_clk) disable iff (!rstn)
        (readStart_q && pbReadDone) |=> !readStart_q && {dataByte3_q, dataByte2_q} == $past(pbReadData[31:16]))
        else $error("indirect read result not stored");
    a_cksum_cfg: assert property (@(posedge ref_clk) disable iff (!rstn)
        lastCfg |=> cfgDone_q && cfgOk_q == ($past(accSum[7:0]) == 8'h00))
        else $error("configuration checksum wrong");
    a_cksum_id: assert property (@(posedge ref_clk) disable iff (!rstn)
        lastId |=> idOk_q == ($past(accSum[7:0]) == 8'h00) && initDone_q ##1 !idWrEn_q)
        else $error("id checksum wrong");
endmodule

//--- src/brs_pkg.sv
// What this block does
// - bytes 2 and 3 of indirect data word, byte 3 most significant, reset zero
// - control bit 4 picks timebase source: 0 internal, 1 external oscillator
// - control bit 3 set generates the timebase tick, clear generates none
// - control bit 1 written one reloads id memory from eeprom, self clears
// - bit 2 wipes id memory only with bit 1 together, self clears after
// - control bit 0 read only, caught from strap pin, blocks ddc access
// - status bit 7 follows receiver supply sense input
// - status bit 6 shows pending video receiver interrupt
// - status bit 5 shows pending protection transmitter interrupt
// - status bit 2 at configuration done, bit 4 at init done, 2 first
// - status bit 3 shows id memory loaded from remote eeprom
// - status bit 1 is checksum result over last 128 eeprom bytes
// - status bit 0 is checksum result of the latest id load: first 256 eeprom bytes, or the remote load
// - read start runs indirect read, loads data bytes, then self clears
package brs_pkg;
    // printed offsets are indices; byte address is four times the index
    localparam logic [7:0] IDX_DATA2 = 8'h4d;
    localparam logic [7:0] IDX_DATA3 = 8'h4e;
    localparam logic [7:0] IDX_CTRL = 8'h4f;
    localparam logic [7:0] IDX_STATUS = 8'h50;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h58;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h59;
    localparam logic [7:0] IDX_IND_CTRL = 8'h5a;
    localparam logic [7:0] IDX_IND_ADDR = 8'h5b;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h03;
    localparam int CTL_SRC_BIT = 4;
    localparam int CTL_GEN_BIT = 3;
    localparam int CTL_WIPE_BIT = 2;
    localparam int CTL_RELOAD_BIT = 1;
    localparam int IND_START_BIT = 0;
    localparam int IRQ_W = 5;
    localparam int IRQ_CFG_DONE = 0;
    localparam int IRQ_INIT_DONE = 1;
    localparam int IRQ_RELOAD_DONE = 2;
    localparam int IRQ_REMOTE_LOAD = 3;
    localparam int IRQ_READ_DONE = 4;
    localparam int CFG_REGION_BYTES = 128;
    localparam int ID_REGION_BYTES = 256;
    localparam int STRAP_SETTLE = 3;
    localparam longint CEC_TB_HZ = 32768;
    localparam longint REF_CLK_HZ = 10_000_000;
    localparam int CEC_ACC_W = 24;
    localparam longint CEC_INC_L = (CEC_TB_HZ * (64'd1 << CEC_ACC_W) + REF_CLK_HZ / 2) / REF_CLK_HZ;
    localparam logic [CEC_ACC_W-1:0] CEC_ACC_INC = CEC_INC_L[CEC_ACC_W-1:0];
    localparam int TB_MIN_GAP = 8;

    typedef enum logic [1:0] {
        ST_CFG = 2'b00,
        ST_ID = 2'b01,
        ST_WIPE = 2'b10,
        ST_RUN = 2'b11
    } brs_seq_t;

    typedef struct packed {
        logic [2:0] rsvd;
        logic cecTimebaseSourceSel;
        logic cecTimebaseGenOn;
        logic displayIdMemWipe;
        logic displayIdMemReload;
        logic displayIdDdcBlock;
    } brs_ctrl_t;

    typedef struct packed {
        logic receiverSupplySense;
        logic videoRxIrqPending;
        logic protectTxIrqPending;
        logic initDone;
        logic remoteDisplayIdLoaded;
        logic cfgDone;
        logic configChecksumOk;
        logic displayIdChecksumOk;
    } brs_status_t;
endpackage

//--- sim/brs_bridge_regs_tb_top.sv
`timescale 1ns/10ps
module brs_bridge_regs_tb_top;
    import brs_pkg::*;
    logic ref_clk, rstn, hsel, hwrite, extTimebaseTick, wipeMode;
    logic firstModeStrapPin, receiverSupplyInput, videoRxIrqIn, protectTxIrqIn, remoteIdLoadDone, remoteIdSumOk;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [31:0] pbReadData = 32'h0;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, irq, cecTick, eeReq, idWrEn, displayIdDdcBlock, pbReadReq;
    logic eeAck = 1'b0;
    logic pbReadDone = 1'b0;
    wire hready = hreadyout;
    logic [8:0] eeAddr;
    logic [7:0] eeData = 8'h00;
    logic [7:0] idWrAddr, idWrData;
    logic [15:0] pbAddr, pbLowData;
    logic [7:0] ee [512];
    int fails, checks, idWrites, ticks, pbWait;

    brs_bridge_regs u_brs_bridge_regs (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .firstModeStrapPin(firstModeStrapPin),
        .receiverSupplyInput(receiverSupplyInput), .videoRxIrqIn(videoRxIrqIn), .protectTxIrqIn(protectTxIrqIn),
        .extTimebaseTick(extTimebaseTick), .cecTick(cecTick), .eeReq(eeReq), .eeAddr(eeAddr), .eeAck(eeAck),
        .eeData(eeData), .idWrEn(idWrEn), .idWrAddr(idWrAddr), .idWrData(idWrData),
        .displayIdDdcBlock(displayIdDdcBlock), .remoteIdLoadDone(remoteIdLoadDone), .remoteIdSumOk(remoteIdSumOk),
        .pbReadReq(pbReadReq), .pbAddr(pbAddr), .pbReadDone(pbReadDone), .pbReadData(pbReadData),
        .pbLowData(pbLowData));

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // samples ready and read data mid-cycle so the edge itself carries no race
    task automatic hwait();
        int n;
        logic ok;
        n = 0;
        do begin
            @(negedge ref_clk);
            ok = hreadyout;
            rd = hrdata;
            @(posedge ref_clk);
            n++;
        end while (ok !== 1'b1 && n < 100);
        if (ok !== 1'b1) begin
            fails++;
            give_verdict();
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        hwait();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        hwait();
    endtask

    task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
        ahb(1'b0, idx, 32'h0);
        chk(what, exp, rd);
    endtask

    // polls until the self-clearing control bits drop
    task automatic waitctl(input logic [7:0] m);
        int n;
        n = 0;
        do begin
            ahb(1'b0, IDX_CTRL, 32'h0);
            n++;
        end while ((rd[7:0] & m) != 8'h00 && n < 1000);
        chk("ctrl self clear", 32'h0, {24'h0, rd[7:0] & m});
    endtask

    task automatic fix(input int lo, input int hi);
        logic [7:0] s;
        s = 8'h00;
        for (int i = lo; i < hi; i++) s += ee[i];
        ee[hi] = -s;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        #(100 * 100000);
        fails++;
        give_verdict();
    end

    // eeprom and indirect bus responders; released data lines show inverted junk
    always @(posedge ref_clk) begin
        eeAck <= eeReq && !eeAck;
        eeData <= eeReq ? ee[eeAddr] : ~eeData;
        pbWait <= (pbReadReq && !pbReadDone) ? pbWait + 1 : 0;
        pbReadDone <= (pbWait == 3);
        pbReadData <= (pbWait == 3) ? 32'hdeadbeef : ~pbReadData;
        if (cecTick === 1'b1) ticks++;
        if (idWrEn === 1'b1) begin
            idWrites++;
            chk("idWrData", {24'h0, wipeMode ? 8'h00 : ee[idWrAddr]}, {24'h0, idWrData});
        end
    end

    initial begin
        rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
        extTimebaseTick = 1'b0; firstModeStrapPin = 1'b1; receiverSupplyInput = 1'b0; videoRxIrqIn = 1'b0;
        protectTxIrqIn = 1'b0; remoteIdLoadDone = 1'b0; remoteIdSumOk = 1'b0; wipeMode = 1'b0;
        for (int i = 0; i < 512; i++) ee[i] = i[7:0];
        fix(0, 255);
        fix(384, 511);
        cyc(12);
        rstn <= 1'b1;
        rdc("status reset", IDX_STATUS, 32'h03);
        rdc("byte2 reset", IDX_DATA2, 32'h0);
        rdc("byte3 reset", IDX_DATA3, 32'h0);
        rdc("ctrl strap", IDX_CTRL, 32'h01);
        for (int n = 0; n < 1000 && rd[4] !== 1'b1; n++) ahb(1'b0, IDX_STATUS, 32'h0);
        chk("init done", 32'h1, {31'h0, rd[4]});
        chk("cfg done with init", 32'h1, {31'h0, rd[2]});
        rdc("status loaded", IDX_STATUS, 32'h17);
        ahb(1'b1, IDX_DATA2, 32'ha5);
        ahb(1'b1, IDX_DATA3, 32'h5a);
        rdc("byte2", IDX_DATA2, 32'ha5);
        rdc("byte3", IDX_DATA3, 32'h5a);
        for (int i = 5; i < 8; i++) begin
            {receiverSupplyInput, videoRxIrqIn, protectTxIrqIn} <= 3'b100 >> (7 - i);
            cyc(6);
            rdc("status live", IDX_STATUS, 32'h17 | (32'h1 << i));
        end
        {receiverSupplyInput, videoRxIrqIn, protectTxIrqIn} <= 3'b000;
        ahb(1'b1, IDX_CTRL, 32'h0);
        rdc("strap read only", IDX_CTRL, 32'h01);
        chk("ddc block", 32'h1, {31'h0, displayIdDdcBlock});
        ahb(1'b1, IDX_CTRL, 32'h08);
        ticks = 0;
        cyc(1000);
        chk("internal ticks", 32'h1, {31'h0, ticks >= 3 && ticks <= 4});
        ahb(1'b1, IDX_CTRL, 32'h0);
        cyc(5);
        ticks = 0;
        cyc(1000);
        chk("ticks off", 32'h0, ticks);
        ahb(1'b1, IDX_CTRL, 32'h18);
        rdc("ctrl src", IDX_CTRL, 32'h19);
        ticks = 0;
        repeat (5) begin
            extTimebaseTick <= 1'b1;
            cyc(10);
            extTimebaseTick <= 1'b0;
            cyc(10);
        end
        chk("ext ticks", 32'h5, ticks);
        ahb(1'b1, IDX_CTRL, 32'h0);
        ee[5] = ee[5] + 8'h01;
        idWrites = 0;
        ahb(1'b1, IDX_CTRL, 32'h02);
        waitctl(8'h02);
        chk("reload writes", 32'd256, idWrites);
        rdc("bad id sum", IDX_STATUS, 32'h16);
        wipeMode = 1'b1;
        idWrites = 0;
        ahb(1'b1, IDX_CTRL, 32'h06);
        waitctl(8'h06);
        chk("wipe writes", 32'd256, idWrites);
        wipeMode = 1'b0;
        idWrites = 0;
        ahb(1'b1, IDX_CTRL, 32'h04);
        cyc(300);
        chk("wipe alone", 32'h0, idWrites);
        ahb(1'b1, IDX_CTRL, 32'h0);
        remoteIdSumOk <= 1'b1;
        remoteIdLoadDone <= 1'b1;
        cyc(1);
        remoteIdLoadDone <= 1'b0;
        cyc(2);
        rdc("remote load", IDX_STATUS, 32'h1f);
        ahb(1'b1, IDX_IRQ_STAT, 32'h1f);
        ahb(1'b1, IDX_IRQ_MASK, 32'h0);
        ahb(1'b1, IDX_IND_ADDR, 32'h1234);
        ahb(1'b1, IDX_IND_CTRL, 32'h1);
        chk("pbAddr", 32'h1234, {16'h0, pbAddr});
        cyc(10);
        rdc("start clear", IDX_IND_CTRL, 32'h0);
        rdc("read byte2", IDX_DATA2, 32'had);
        rdc("read byte3", IDX_DATA3, 32'hde);
        chk("low bytes", 32'hbeef, {16'h0, pbLowData});
        chk("irq masked", 32'h0, {31'h0, irq});
        rdc("irq status", IDX_IRQ_STAT, 32'h10);
        ahb(1'b1, IDX_IRQ_MASK, 32'h10);
        @(negedge ref_clk);
        chk("irq on", 32'h1, {31'h0, irq});
        ahb(1'b1, IDX_IRQ_STAT, 32'h10);
        @(negedge ref_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rdc("unmapped", 8'hff, 32'h0);
        chk("hresp okay", 32'h0, {31'h0, hresp});
        give_verdict();
    end
endmodule
